// *** shared/grlc_pkg.sv ***
// package: register map, field layout and codes for the remote/local control block
package grlc_pkg;

    // ==================================================================
    // register byte offsets
    localparam logic [7:0] GRLC_REG_CTRL      = 8'h00;
    localparam logic [7:0] GRLC_REG_STATUS    = 8'h04;
    localparam logic [7:0] GRLC_REG_STB       = 8'h08;
    localparam logic [7:0] GRLC_REG_SRQ_MASK  = 8'h0C;
    localparam logic [7:0] GRLC_REG_ERROR     = 8'h10;
    localparam logic [7:0] GRLC_REG_READY     = 8'h14;
    localparam logic [7:0] GRLC_REG_ALARM_CHG = 8'h18;
    localparam logic [7:0] GRLC_REG_KEY       = 8'h1C;
    localparam logic [7:0] GRLC_REG_STB_SET   = 8'h20;

    // ==================================================================
    // control register bits (write one to act)
    localparam int GRLC_CTRL_LOCAL_CMD = 0;
    localparam int GRLC_CTRL_CFG_CMD   = 1;
    localparam int GRLC_CTRL_GATE_ON   = 2;

    // status byte bit positions
    localparam int GRLC_STB_FPS = 2;
    localparam int GRLC_STB_ERR = 5;
    localparam int GRLC_STB_RQS = 6;

    // ==================================================================
    // reset and clear values
    localparam logic [7:0]  GRLC_MASK_CLEAR  = 8'h20;
    localparam logic [7:0]  GRLC_READY_CLEAR = 8'h01;
    localparam logic [15:0] GRLC_ERR_NONE    = 16'h0000;
    // -201 as a two's complement 16-bit code
    localparam logic [15:0] GRLC_ERR_LOCAL   = 16'hFF37;
    localparam logic [31:0] GRLC_ZERO_WORD   = 32'h0000_0000;

    // ==================================================================
    // remote/local states
    typedef enum logic [1:0] {
        GRLC_LOCS = 2'b00,
        GRLC_REMS = 2'b01,
        GRLC_LWLS = 2'b10,
        GRLC_REMOTE_WITH_LOCKOUT_STATE = 2'b11
    } grlc_rl_t;

    // front-panel key bit positions
    localparam int GRLC_KEY_PAGE   = 0;
    localparam int GRLC_KEY_CURSOR = 1;
    localparam int GRLC_KEY_CHANGE = 2;
    localparam int GRLC_KEY_RUN    = 3;
    localparam int GRLC_KEY_START  = 4;
    localparam int GRLC_KEY_AUDIO  = 5;
    localparam int GRLC_KEY_LOCAL  = 6;
    localparam int GRLC_KEYS       = 7;

endpackage

// *** rtl/grlc_rl_fsm.sv ***
// remote/local state machine with latched lockout
module grlc_rl_fsm
    import grlc_pkg::*;
(
    // clock and reset
    input  wire logic     hclk,
    input  wire logic     hresetn,
    // bus events
    input  wire logic     ren,
    input  wire logic     listen_addr,
    input  wire logic     llo,
    input  wire logic     gtl,
    // device requests
    input  wire logic     local_return_command,
    input  wire logic     panel_local,
    // state
    output grlc_rl_t      state
);

    // ==================================================================
    // next state
    grlc_rl_t next_state;
    logic     lockout;

    assign lockout = (state == GRLC_LWLS) || (state == GRLC_REMOTE_WITH_LOCKOUT_STATE);

    always_comb begin
        next_state = state;
        if (!ren) begin
            next_state = GRLC_LOCS;
        end else begin
            case (state)
                GRLC_LOCS: begin
                    if (listen_addr)
                        next_state = llo ? GRLC_REMOTE_WITH_LOCKOUT_STATE : GRLC_REMS;
                    else if (llo)
                        next_state = GRLC_LWLS;
                end
                GRLC_REMS: begin
                    if (gtl || local_return_command || panel_local)
                        next_state = llo ? GRLC_LWLS : GRLC_LOCS;
                    else if (llo)
                        next_state = GRLC_REMOTE_WITH_LOCKOUT_STATE;
                end
                GRLC_LWLS: begin
                    if (listen_addr)
                        next_state = GRLC_REMOTE_WITH_LOCKOUT_STATE;
                end
                GRLC_REMOTE_WITH_LOCKOUT_STATE: begin
                    if (gtl || local_return_command)
                        next_state = GRLC_LWLS;
                end
                default: next_state = GRLC_LOCS;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            state <= GRLC_LOCS;
        else
            state <= next_state;
    end

endmodule

// *** rtl/grlc_srq.sv ***
// status byte, mask and service request line
module grlc_srq
    import grlc_pkg::*;
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // controls
    input  wire logic       clear,
    input  wire logic       poll_done,
    input  wire logic [7:0] set_bits,
    input  wire logic [7:0] clr_bits,
    input  wire logic       mask_we,
    input  wire logic [7:0] mask_wdata,
    // state
    output logic      [7:0] stb,
    output logic      [7:0] mask,
    output logic            srq
);

    // ==================================================================
    // sticky status bits: set wins over clear
    logic [7:0] next_stb;
    logic       next_srq;

    assign next_stb = clear ? set_bits : ((stb & ~clr_bits) | set_bits);
    assign next_srq = |(next_stb & mask & ~(8'h01 << GRLC_STB_RQS));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stb  <= 8'h00;
            mask <= GRLC_MASK_CLEAR;
        end else if (clear) begin
            stb  <= next_stb;
            mask <= GRLC_MASK_CLEAR;
        end else begin
            stb  <= next_stb;
            if (mask_we)
                mask <= mask_wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            srq <= 1'b0;
        else if (poll_done || clear)
            srq <= 1'b0;
        else if (next_srq && !srq)
            srq <= 1'b1;
        else if (!next_srq)
            srq <= 1'b0;
    end

endmodule

// *** rtl/grlc_top.sv ***
// remote/local control top: bus messages, key gating, registers on ahb-lite
//
// Overview of operation
// - clear stops gating, flushes, drops service
// - clear sets mask to error only
// - clear empties errors and key; status and alarm keep only bits set in the clearing cycle
// - clear loads ready register with one
// - interface clear idles listener only
// - serial poll returns primary status byte
// - completed poll releases service request
// - remote enable plus listen gives remote
// - remote lights indicator, and listen status when also addressed
// - local config command raises error -201
// - remote disables run, start, audio keys
// - lockout disables local key only
// - remote with lockout panel local sets service flag
// - bus-wide return cancels lockout
// - addressed local keeps lockout latched
// - power on starts local
// - go-to-local or command returns local
// - panel local ignored under lockout
module grlc_top
    import grlc_pkg::*;
#(
    parameter int KEYS = GRLC_KEYS
)
(
    // clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // ahb-lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // bus messages from the interface logic
    input  wire logic            ren,
    input  wire logic            listen_addr,
    input  wire logic            llo,
    input  wire logic            gtl,
    input  wire logic            dev_clear,
    input  wire logic            ifc,
    input  wire logic            poll_req,
    input  wire logic            poll_done,
    // front panel
    input  wire logic [KEYS-1:0] keys_raw,
    input  wire logic [7:0]      alarm_change,
    // answers and indicators
    output logic      [7:0]      poll_byte,
    output logic                 srq,
    output logic                 remote_led,
    output logic                 listen_status,
    output logic                 lockout_status,
    output logic                 listener_idle,
    output logic                 gating,
    output logic                 flush,
    output logic      [KEYS-1:0] keys_out
);

    // ==================================================================
    // bus decode
    logic        ap_write;
    logic        ap_read;
    logic [7:0]  ap_addr;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic        take;

    assign take     = hsel && hready && htrans[1];
    assign ap_write = take && hwrite;
    assign ap_read  = take && !hwrite;
    assign ap_addr  = haddr[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= ap_write;
            dp_addr  <= ap_addr;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // write strobes in the data phase
    logic we_ctrl;
    logic we_mask;
    logic we_stb_set;
    logic we_error;
    logic we_ready;

    assign we_ctrl    = dp_write && hit(dp_addr, GRLC_REG_CTRL);
    assign we_mask    = dp_write && hit(dp_addr, GRLC_REG_SRQ_MASK);
    assign we_stb_set = dp_write && hit(dp_addr, GRLC_REG_STB_SET);
    assign we_error   = dp_write && hit(dp_addr, GRLC_REG_ERROR);
    assign we_ready   = dp_write && hit(dp_addr, GRLC_REG_READY);

    logic local_return_command;
    logic cfg_cmd;
    logic gate_on;

    assign local_return_command = we_ctrl && hwdata[GRLC_CTRL_LOCAL_CMD];
    assign cfg_cmd              = we_ctrl && hwdata[GRLC_CTRL_CFG_CMD];
    assign gate_on              = we_ctrl && hwdata[GRLC_CTRL_GATE_ON];

    // ==================================================================
    // remote/local state
    grlc_rl_t rl_state;
    logic     panel_local;
    logic     is_remote;
    logic     is_lockout;

    assign panel_local = keys_raw[GRLC_KEY_LOCAL];

    grlc_rl_fsm u_fsm (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .ren                  (ren),
        .listen_addr          (listen_addr),
        .llo                  (llo),
        .gtl                  (gtl),
        .local_return_command (local_return_command),
        .panel_local          (panel_local),
        .state                (rl_state)
    );

    assign is_remote  = (rl_state == GRLC_REMS) || (rl_state == GRLC_REMOTE_WITH_LOCKOUT_STATE);
    assign is_lockout = (rl_state == GRLC_LWLS) || (rl_state == GRLC_REMOTE_WITH_LOCKOUT_STATE);

    // ==================================================================
    // status byte and service request
    logic [7:0] stb;
    logic [7:0] mask;
    logic       srq_int;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic       fps_set;
    logic       err_set;

    // panel local under remote with lockout flags service
    assign fps_set  = (rl_state == GRLC_REMOTE_WITH_LOCKOUT_STATE) && panel_local;
    assign err_set  = cfg_cmd && !is_remote;
    assign set_bits = ({7'h00, fps_set} << GRLC_STB_FPS)
                    | ({7'h00, err_set} << GRLC_STB_ERR)
                    | (we_stb_set ? hwdata[7:0] : 8'h00);
    assign clr_bits = (we_error ? (8'h01 << GRLC_STB_ERR) : 8'h00)
                    | (poll_done ? (8'h01 << GRLC_STB_FPS) : 8'h00);

    grlc_srq u_srq (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clear      (dev_clear),
        .poll_done  (poll_done),
        .set_bits   (set_bits),
        .clr_bits   (clr_bits),
        .mask_we    (we_mask),
        .mask_wdata (hwdata[7:0]),
        .stb        (stb),
        .mask       (mask),
        .srq        (srq_int)
    );

    // ==================================================================
    // error, ready, alarm change and key registers
    logic [15:0]     err_code;
    logic [7:0]      ready_reg;
    logic [7:0]      alarm_reg;
    logic [KEYS-1:0] key_reg;
    logic [KEYS-1:0] key_en;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_code  <= GRLC_ERR_NONE;
            ready_reg <= GRLC_READY_CLEAR;
            alarm_reg <= 8'h00;
            key_reg   <= '0;
        end else if (dev_clear) begin
            err_code  <= GRLC_ERR_NONE;
            ready_reg <= GRLC_READY_CLEAR;
            alarm_reg <= alarm_change;
            key_reg   <= '0;
        end else begin
            if (err_set)
                err_code <= GRLC_ERR_LOCAL;
            else if (we_error)
                err_code <= GRLC_ERR_NONE;
            if (we_ready)
                ready_reg <= hwdata[7:0];
            alarm_reg <= alarm_reg | alarm_change;
            key_reg   <= key_reg | (keys_raw & key_en);
        end
    end

    // ==================================================================
    // key gating
    genvar k;
    generate
        for (k = 0; k < KEYS; k++) begin : g_key
            if (k == GRLC_KEY_RUN || k == GRLC_KEY_START || k == GRLC_KEY_AUDIO) begin : g_fn
                assign key_en[k] = !is_remote;
            end else if (k == GRLC_KEY_LOCAL) begin : g_loc
                assign key_en[k] = !is_lockout;
            end else begin : g_nav
                assign key_en[k] = 1'b1;
            end
        end
    endgenerate

    // ==================================================================
    // read mux
    logic [31:0] rd_mux;

    assign rd_mux =
        hit(ap_addr, GRLC_REG_STATUS)    ? {28'h0, is_lockout, listen_addr, is_remote,
                                            rl_state == GRLC_LOCS} :
        hit(ap_addr, GRLC_REG_STB)       ? {24'h0, stb | ({7'h00, srq_int} << GRLC_STB_RQS)} :
        hit(ap_addr, GRLC_REG_SRQ_MASK)  ? {24'h0, mask} :
        hit(ap_addr, GRLC_REG_ERROR)     ? {16'h0, err_code} :
        hit(ap_addr, GRLC_REG_READY)     ? {24'h0, ready_reg} :
        hit(ap_addr, GRLC_REG_ALARM_CHG) ? {24'h0, alarm_reg} :
        hit(ap_addr, GRLC_REG_KEY)       ? {{(32-KEYS){1'b0}}, key_reg} :
                                           GRLC_ZERO_WORD;

    // ==================================================================
    // registered outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata         <= GRLC_ZERO_WORD;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            poll_byte      <= 8'h00;
            srq            <= 1'b0;
            remote_led     <= 1'b0;
            listen_status  <= 1'b0;
            lockout_status <= 1'b0;
            listener_idle  <= 1'b1;
            gating         <= 1'b0;
            flush          <= 1'b0;
            keys_out       <= '0;
        end else begin
            hrdata         <= ap_read ? rd_mux : GRLC_ZERO_WORD;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            if (poll_req)
                poll_byte <= stb | ({7'h00, srq_int} << GRLC_STB_RQS);
            srq            <= srq_int && !poll_done && !dev_clear;
            remote_led     <= is_remote;
            listen_status  <= is_remote && listen_addr;
            lockout_status <= is_lockout;
            listener_idle  <= ifc || !listen_addr;
            if (dev_clear)
                gating <= 1'b0;
            else if (gate_on)
                gating <= 1'b1;
            flush          <= dev_clear;
            keys_out       <= keys_raw & key_en;
        end
    end

endmodule

// *** verification/grlc_top_props.sv ***
// concurrent checks on the remote/local control top ports
module grlc_props
    import grlc_pkg::*;
#(
    parameter int KEYS = GRLC_KEYS
)
(
    // clock and reset
    input wire logic            hclk,
    input wire logic            hresetn,
    // bus messages
    input wire logic            ren,
    input wire logic            listen_addr,
    input wire logic            gtl,
    input wire logic            dev_clear,
    input wire logic            ifc,
    input wire logic            poll_req,
    input wire logic            poll_done,
    // answers and indicators
    input wire logic [7:0]      poll_byte,
    input wire logic            srq,
    input wire logic            remote_led,
    input wire logic            lockout_status,
    input wire logic            listener_idle,
    input wire logic            gating,
    input wire logic            flush,
    input wire logic [KEYS-1:0] keys_out
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // sequences
    sequence s_addr;
        ren && listen_addr && !gtl ##1 ren && listen_addr && !gtl;
    endsequence
    sequence s_remote;
        remote_led [*3];
    endsequence
    sequence s_locked;
        (remote_led && lockout_status && ren && !gtl) [*3];
    endsequence

    // ==========================================================
    // properties
    chk_remote_entry: assert property (s_addr |-> ##[1:3] remote_led)
        else $error("remote state not entered");
    chk_remote_keys: assert property (s_remote |-> !keys_out[GRLC_KEY_RUN]
        && !keys_out[GRLC_KEY_START] && !keys_out[GRLC_KEY_AUDIO])
        else $error("run, start or audio key passed in remote");
    chk_lock_key: assert property (s_locked |-> !keys_out[GRLC_KEY_LOCAL])
        else $error("local key passed under lockout");
    chk_lock_holds: assert property (s_locked |=> remote_led)
        else $error("left remote under lockout");
    chk_ren_release: assert property (!ren [*3] |-> !remote_led && !lockout_status)
        else $error("remote or lockout kept without remote enable");
    chk_clear_flush: assert property (dev_clear |-> ##[1:2] flush ##[0:1] !gating)
        else $error("clear did not flush and stop gating");
    chk_clear_srq: assert property (dev_clear |=> !srq ##1 !srq)
        else $error("service request kept after clear");
    chk_poll_release: assert property (poll_done && !dev_clear |=> !srq)
        else $error("service request kept after poll");
    chk_poll_rqs: assert property (poll_req && !poll_done && !dev_clear
        |=> poll_byte[GRLC_STB_RQS] == srq)
        else $error("poll byte request bit wrong");
    chk_srq_cause: assert property ($rose(srq) |-> !$past(poll_done) && !$past(dev_clear))
        else $error("service request rose right after release");
    chk_ifc_idle: assert property (ifc |-> ##[1:3] listener_idle)
        else $error("listener not idle after interface clear");
endmodule

bind grlc_top grlc_props #(.KEYS(KEYS)) u_props (
    .hclk(hclk), .hresetn(hresetn), .ren(ren), .listen_addr(listen_addr), .gtl(gtl),
    .dev_clear(dev_clear), .ifc(ifc), .poll_req(poll_req), .poll_done(poll_done),
    .poll_byte(poll_byte), .srq(srq), .remote_led(remote_led),
    .lockout_status(lockout_status), .listener_idle(listener_idle), .gating(gating),
    .flush(flush), .keys_out(keys_out)
);

// *** verification/grlc_ctrl_model.sv ***
// bus controller model driving the bus messages
module grlc_ctrl_model
(
    // clock and answer
    input  wire logic       hclk,
    input  wire logic [7:0] poll_byte,
    // bus messages
    output logic            ren,
    output logic            listen_addr,
    output logic            llo,
    output logic            gtl,
    output logic            dev_clear,
    output logic            ifc,
    output logic            poll_req,
    output logic            poll_done
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {ren, listen_addr, llo, gtl, dev_clear, ifc, poll_req, poll_done} = 8'h0;
    end

    task automatic address(input logic r, input logic l);
        @(posedge hclk);
        ren <= r;
        listen_addr <= l;
    endtask

    // one-cycle message: 0 go-to-local, 1 clear, 2 interface clear, 3 lockout
    task automatic pulse(input int k);
        @(posedge hclk);
        case (k)
            0: gtl <= 1'b1;
            1: dev_clear <= 1'b1;
            2: begin
                // interface clear also unaddresses every listener
                ifc <= 1'b1;
                listen_addr <= 1'b0;
            end
            default: llo <= 1'b1;
        endcase
        @(posedge hclk);
        {gtl, dev_clear, ifc, llo} <= 4'h0;
    endtask

    task automatic lockout();
        if (ren !== 1'b1) begin
            address(1'b1, listen_addr);
        end
        pulse(3);
    endtask

    // poll enable, read byte, poll disable
    task automatic poll(input int slow, output logic [7:0] sb);
        @(posedge hclk);
        poll_req <= 1'b1;
        @(posedge hclk);
        poll_req <= 1'b0;
        @(posedge hclk);
        sb = poll_byte;
        repeat (slow) @(posedge hclk);
        poll_done <= 1'b1;
        @(posedge hclk);
        poll_done <= 1'b0;
    endtask
endmodule

// *** verification/tb_grlc_top.sv ***
// self-checking bench for the remote/local control block
module tb_grlc_top
    import grlc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, srq, gating, flush;
    logic        ren, listen_addr, llo, gtl, dev_clear, ifc, poll_req, poll_done;
    logic        remote_led, listen_status, lockout_status, listener_idle, rd_dp;
    logic [31:0] haddr, hwdata, hrdata, seed;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  alarm_change, poll_byte, sb;
    logic [6:0]  keys_raw, keys_out;
    logic [31:0] exp_q[$];
    int          miscompares, num_checks;

    grlc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ren(ren),
        .listen_addr(listen_addr), .llo(llo), .gtl(gtl), .dev_clear(dev_clear), .ifc(ifc),
        .poll_req(poll_req), .poll_done(poll_done), .keys_raw(keys_raw),
        .alarm_change(alarm_change), .poll_byte(poll_byte), .srq(srq),
        .remote_led(remote_led), .listen_status(listen_status),
        .lockout_status(lockout_status), .listener_idle(listener_idle), .gating(gating),
        .flush(flush), .keys_out(keys_out));
    grlc_ctrl_model u_ctl (.hclk(hclk), .poll_byte(poll_byte), .ren(ren),
        .listen_addr(listen_addr), .llo(llo), .gtl(gtl), .dev_clear(dev_clear), .ifc(ifc),
        .poll_req(poll_req), .poll_done(poll_done));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // read data monitor: oldest note against the data phase
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            chk(hrdata, exp_q.pop_front());
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        tk(5000);
        miscompares++;
        finish_test();
    end

    // ==========================================================
    // scenarios
    initial begin
        {hresetn, hsel, hwrite, rd_dp} = 4'h0;
        {haddr, hwdata} = 64'h0;
        {htrans, hsize, alarm_change, keys_raw} = {2'b00, 3'b010, 8'h0, 7'h0};
        seed = 32'h0000_680d;
        tk(12);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'({remote_led, lockout_status, listener_idle}), 32'h1);
        chk(32'({hresp, hreadyout}), 32'h1);
        rd(GRLC_REG_STATUS, 32'h1);
        rd(GRLC_REG_SRQ_MASK, 32'h20);
        bus(8'h40, 1'b1, 32'hffff_ffff);
        rd(8'h40, 32'h0);
        bus(GRLC_REG_CTRL, 1'b1, 32'h2);
        rd(GRLC_REG_ERROR, 32'hff37);
        tk(5);
        chk(32'(srq), 32'h1);
        u_ctl.poll(0, sb);
        chk(32'(sb), 32'h60);
        bus(GRLC_REG_ERROR, 1'b1, 32'h0);
        tk(5);
        chk(32'(srq), 32'h0);
        rd(GRLC_REG_STB, 32'h0);
        u_ctl.address(1'b1, 1'b1);
        keys_raw <= 7'h3f;
        tk(5);
        chk(32'({remote_led, listen_status, keys_out}), 32'h187);
        rd(GRLC_REG_STATUS, 32'h6);
        bus(GRLC_REG_CTRL, 1'b1, 32'h2);
        rd(GRLC_REG_ERROR, 32'h0);
        bus(GRLC_REG_SRQ_MASK, 1'b1, 32'h4);
        keys_raw <= 7'h0;
        u_ctl.lockout();
        keys_raw <= 7'h7f;
        tk(5);
        chk(32'({remote_led, srq, keys_out}), 32'h187);
        rd(GRLC_REG_STATUS, 32'he);
        keys_raw <= 7'h0;
        u_ctl.poll(5, sb);
        chk(32'(sb), 32'h44);
        tk(2);
        chk(32'(srq), 32'h0);
        u_ctl.address(1'b1, 1'b0);
        // controller returns the device to local
        u_ctl.pulse(0);
        tk(5);
        chk(32'({remote_led, lockout_status}), 32'h1);
        u_ctl.address(1'b1, 1'b1);
        tk(5);
        chk(32'({remote_led, lockout_status}), 32'h3);
        u_ctl.address(1'b0, 1'b0);
        tk(5);
        rd(GRLC_REG_STATUS, 32'h1);
        for (int i = 0; i < 3; i++) begin
            u_ctl.address(1'b1, 1'b1);
            tk(5);
            u_ctl.address(1'b1, 1'b0);
            if (i == 0) begin
                u_ctl.pulse(0);
            end else if (i == 1) begin
                bus(GRLC_REG_CTRL, 1'b1, 32'h1);
            end else begin
                keys_raw <= 7'h40;
            end
            tk(5);
            chk(32'(remote_led), 32'h0);
            keys_raw <= 7'h0;
        end
        u_ctl.address(1'b0, 1'b0);
        seed = xs(seed);
        bus(GRLC_REG_CTRL, 1'b1, 32'h4);
        bus(GRLC_REG_READY, 1'b1, seed);
        bus(GRLC_REG_SRQ_MASK, 1'b1, 32'hff);
        bus(GRLC_REG_STB_SET, 1'b1, 32'h1);
        bus(GRLC_REG_CTRL, 1'b1, 32'h2);
        alarm_change <= seed[15:8] | 8'h1;
        @(posedge hclk);
        alarm_change <= 8'h0;
        rd(GRLC_REG_READY, {24'h0, seed[7:0]});
        rd(GRLC_REG_ALARM_CHG, {24'h0, seed[15:8] | 8'h1});
        chk(32'({gating, srq}), 32'h3);
        u_ctl.pulse(1);
        tk(3);
        chk(32'({gating, srq}), 32'h0);
        rd(GRLC_REG_SRQ_MASK, 32'h20);
        rd(GRLC_REG_ERROR, 32'h0);
        rd(GRLC_REG_STB, 32'h0);
        rd(GRLC_REG_ALARM_CHG, 32'h0);
        rd(GRLC_REG_KEY, 32'h0);
        rd(GRLC_REG_READY, 32'h1);
        seed = xs(seed);
        bus(GRLC_REG_READY, 1'b1, seed);
        u_ctl.address(1'b1, 1'b1);
        tk(5);
        u_ctl.pulse(2);
        tk(2);
        chk(32'(listener_idle), 32'h1);
        rd(GRLC_REG_READY, {24'h0, seed[7:0]});
        u_ctl.address(1'b0, 1'b0);
        tk(5);
        finish_test();
    end
endmodule
